// ==== hw/wdog_pkg.sv ====
package wdog_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

	// ****************************************
	// field widths and limits
	// ****************************************
	localparam int PERIOD_SEL_W = 4;
	localparam int EXPIRY_W = 3;
	localparam int MS_COUNT_W = 16;
	localparam int PERIOD_W = 17;
	localparam logic [EXPIRY_W-1:0] EXPIRY_INC = 3'h2;
	localparam logic [EXPIRY_W-1:0] EXPIRY_DEC = 3'h1;
	localparam logic [EXPIRY_W-1:0] EXPIRY_MAX = 3'h7;
	localparam logic [EXPIRY_W-1:0] EXPIRY_MIN = 3'h0;
	localparam logic [EXPIRY_W-1:0] LIMIT_LOW = 3'h2;
	localparam logic [PERIOD_W-1:0] PERIOD_ONE = 17'h00001;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [PERIOD_SEL_W-1:0] RST_PERIOD_SEL = 4'h0;
	localparam logic [EXPIRY_W-1:0] RST_EXPIRY_LIMIT = 3'h0;
	localparam logic [EXPIRY_W-1:0] RST_EXPIRY_COUNT = 3'h0;
	localparam logic [MS_COUNT_W-1:0] RST_MS_COUNT = 16'h0000;
	localparam logic RST_TIMER_ENABLE = 1'b0;
	localparam logic RST_STANDBY_ENABLE = 1'b0;
	localparam logic RST_PIN_TYPE = 1'b0;
	localparam logic RST_FLAG = 1'b0;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic PIN_TYPE_SOFT = 1'b0;
	localparam logic PIN_TYPE_HARD = 1'b1;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_RUN = 2'b01,
		ST_HALT = 2'b10
	} wd_state_t;

	typedef struct packed {
		logic period_wr;
		logic [PERIOD_SEL_W-1:0] period_data;
		logic limit_wr;
		logic [EXPIRY_W-1:0] limit_data;
		logic enable_wr;
		logic enable_data;
		logic secure_write;
		logic standby_wr;
		logic standby_data;
		logic pin_type_wr;
		logic pin_type_data;
		logic refresh_wr;
		logic refresh_data;
	} cfg_write_t;

	typedef struct packed {
		logic [PERIOD_SEL_W-1:0] period_sel;
		logic [EXPIRY_W-1:0] expiry_limit;
		logic timer_enable;
		logic standby_enable;
	} otp_default_t;

endpackage

// ==== hw/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);

	logic stage1;
	logic stage2;
	logic stage3;

	// ****************************************
	// three flops, change counts once two and three agree
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_o <= RESET_VAL;
		end else if (stage2 == stage3) begin
			level_o <= stage3;
		end
	end

endmodule

// ==== hw/ms_tick.sv ====
`timescale 1ns/10ps
module ms_tick #(
	parameter int CYCLES = wdog_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	output logic tick_o
);

	localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] count;

	// ****************************************
	// divider, restarted with every new count
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
			tick_o <= 1'b0;
		end else if (clear_i) begin
			count <= '0;
			tick_o <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick_o <= 1'b1;
		end else begin
			count <= count + CNT_W'(1);
			tick_o <= 1'b0;
		end
	end

endmodule

// ==== hw/wdog_event_mgr.sv ====
`timescale 1ns/10ps
module wdog_event_mgr #(
	parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic host_fail_input_i,
	input wire logic off_mode_i,
	input wire logic system_on_i,
	input wire logic standby_i,
	input wire logic host_reset_out_released_i,
	input wire logic power_up_load_i,
	input wire logic secure_en_i,
	input wire logic window_mode_sel_i,
	input wire wdog_pkg::otp_default_t otp_i,
	input wire wdog_pkg::cfg_write_t cfg_i,
	output logic refresh_pending_flag_o,
	output logic [wdog_pkg::EXPIRY_W-1:0] expiry_counter_o,
	output logic [wdog_pkg::PERIOD_SEL_W-1:0] timer_period_sel_o,
	output logic [wdog_pkg::EXPIRY_W-1:0] expiry_limit_o,
	output logic timer_enable_o,
	output logic standby_timer_enable_o,
	output logic pin_event_reset_type_o,
	output logic [wdog_pkg::MS_COUNT_W-1:0] ms_count_o,
	output logic timer_running_o,
	output logic event_o,
	output logic event_hard_o,
	output logic event_soft_o
);

	// ****************************************
	// declarations
	// ****************************************
	wdog_pkg::wd_state_t state;
	wdog_pkg::wd_state_t next_state;
	logic loaded;
	logic armed;
	logic pin_level;
	logic pin_prev;
	logic tick;
	logic active;
	logic load_now;
	logic period_change;
	logic enable_write_ok;
	logic [wdog_pkg::PERIOD_W-1:0] period;
	logic [wdog_pkg::MS_COUNT_W-1:0] period_last;
	logic [wdog_pkg::MS_COUNT_W-1:0] period_half;
	logic expire;
	logic clear_req;
	logic in_window;
	logic refresh_ok;
	logic refresh_bad;
	logic [wdog_pkg::EXPIRY_W-1:0] next_expiry;
	logic internal_event;
	logic pin_event;

	// ****************************************
	// host fail pin synchroniser
	// ****************************************
	pin_sync #(
		.RESET_VAL(wdog_pkg::PIN_IDLE)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(host_fail_input_i),
		.level_o(pin_level)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_prev <= wdog_pkg::PIN_IDLE;
		end else begin
			pin_prev <= pin_level;
		end
	end

	// falling edge of the filtered pin, ignored in off modes
	assign pin_event = pin_prev && !pin_level && !off_mode_i;

	// ****************************************
	// millisecond tick
	// ****************************************
	// divider held clear until the count is armed
	ms_tick #(
		.CYCLES(TICK_CYCLES)
	) u_ms_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!armed),
		.tick_o(tick)
	);

	// ****************************************
	// configuration bits
	// ****************************************
	// otp defaults win over writes in a load cycle
	assign load_now = !loaded || power_up_load_i;
	// enable writes need the secure flag while secure writes are in force
	assign enable_write_ok = cfg_i.enable_wr && (!secure_en_i || cfg_i.secure_write);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			loaded <= 1'b0;
		end else begin
			loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_period_sel_o <= wdog_pkg::RST_PERIOD_SEL;
		end else if (load_now) begin
			timer_period_sel_o <= otp_i.period_sel;
		end else if (cfg_i.period_wr) begin
			timer_period_sel_o <= cfg_i.period_data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			expiry_limit_o <= wdog_pkg::RST_EXPIRY_LIMIT;
		end else if (load_now) begin
			expiry_limit_o <= otp_i.expiry_limit;
		end else if (cfg_i.limit_wr) begin
			expiry_limit_o <= cfg_i.limit_data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_enable_o <= wdog_pkg::RST_TIMER_ENABLE;
		end else if (load_now) begin
			timer_enable_o <= otp_i.timer_enable;
		end else if (enable_write_ok) begin
			timer_enable_o <= cfg_i.enable_data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			standby_timer_enable_o <= wdog_pkg::RST_STANDBY_ENABLE;
		end else if (load_now) begin
			standby_timer_enable_o <= otp_i.standby_enable;
		end else if (cfg_i.standby_wr) begin
			standby_timer_enable_o <= cfg_i.standby_data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_event_reset_type_o <= wdog_pkg::RST_PIN_TYPE;
		end else if (cfg_i.pin_type_wr) begin
			pin_event_reset_type_o <= cfg_i.pin_type_data;
		end
	end

	// ****************************************
	// period decode and window
	// ****************************************
	// period in ms, its last count and its half point
	assign period = wdog_pkg::PERIOD_ONE << timer_period_sel_o;
	assign period_last = wdog_pkg::MS_COUNT_W'(period - wdog_pkg::PERIOD_ONE);
	assign period_half = wdog_pkg::MS_COUNT_W'(period >> 1);

	// window mode off accepts anywhere, on only in the second half
	assign in_window = !window_mode_sel_i || (ms_count_o >= period_half);

	// ****************************************
	// timer control terms
	// ****************************************
	// runs only in run state, enabled, and not gated by standby
	assign active = (state == wdog_pkg::ST_RUN) && timer_enable_o
		&& !(standby_i && !standby_timer_enable_o);

	assign period_change = cfg_i.period_wr && !load_now && system_on_i
		&& (cfg_i.period_data != timer_period_sel_o);

	// expiry on the tick that ends the last millisecond
	assign expire = active && armed && tick && (ms_count_o == period_last);

	// a zero write or a clear of a clear flag does nothing
	assign clear_req = active && armed && cfg_i.refresh_wr && cfg_i.refresh_data
		&& refresh_pending_flag_o;

	// an expiry in the same cycle as a clear wins
	assign refresh_ok = clear_req && in_window && !expire;
	assign refresh_bad = expire || (clear_req && !in_window);

	// ****************************************
	// expiry counter arithmetic
	// ****************************************
	always_comb begin
		next_expiry = expiry_counter_o;
		if (refresh_bad) begin
			if (expiry_counter_o > (wdog_pkg::EXPIRY_MAX - wdog_pkg::EXPIRY_INC)) begin
				next_expiry = wdog_pkg::EXPIRY_MAX;
			end else begin
				next_expiry = expiry_counter_o + wdog_pkg::EXPIRY_INC;
			end
		end else if (refresh_ok) begin
			if (expiry_counter_o == wdog_pkg::EXPIRY_MIN) begin
				next_expiry = wdog_pkg::EXPIRY_MIN;
			end else begin
				next_expiry = expiry_counter_o - wdog_pkg::EXPIRY_DEC;
			end
		end
	end

	assign internal_event = (refresh_bad || refresh_ok)
		&& ((next_expiry == expiry_limit_o)
		|| (refresh_bad && (expiry_limit_o <= wdog_pkg::LIMIT_LOW)));

	// ****************************************
	// state machine
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			wdog_pkg::ST_WAIT: begin
				if (host_reset_out_released_i) begin
					next_state = wdog_pkg::ST_RUN;
				end
			end
			wdog_pkg::ST_RUN: begin
				if (internal_event) begin
					next_state = wdog_pkg::ST_HALT;
				end
			end
			// halt holds until an off mode
			wdog_pkg::ST_HALT: begin
				next_state = wdog_pkg::ST_HALT;
			end
			default: begin
				next_state = wdog_pkg::ST_WAIT;
			end
		endcase
		if (off_mode_i) begin
			next_state = wdog_pkg::ST_WAIT;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= wdog_pkg::ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// timer count and refresh flag
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed <= 1'b0;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
			refresh_pending_flag_o <= wdog_pkg::RST_FLAG;
		end else if (off_mode_i) begin
			armed <= 1'b0;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
			refresh_pending_flag_o <= wdog_pkg::RST_FLAG;
		end else if (!active) begin
			armed <= 1'b0;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
		end else if (!armed) begin
			// new count: arm, restart count, set flag
			armed <= 1'b1;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
			refresh_pending_flag_o <= 1'b1;
		end else if (refresh_ok) begin
			armed <= 1'b0;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
			refresh_pending_flag_o <= 1'b0;
		end else if (refresh_bad || period_change) begin
			armed <= 1'b0;
			ms_count_o <= wdog_pkg::RST_MS_COUNT;
		end else if (tick) begin
			ms_count_o <= ms_count_o + wdog_pkg::MS_COUNT_W'(1);
		end
	end

	// registered view of the gated timer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_running_o <= 1'b0;
		end else begin
			timer_running_o <= active && !off_mode_i;
		end
	end

	// ****************************************
	// expiry counter register
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			expiry_counter_o <= wdog_pkg::RST_EXPIRY_COUNT;
		end else if (off_mode_i) begin
			expiry_counter_o <= wdog_pkg::RST_EXPIRY_COUNT;
		end else begin
			// moves only on a refresh or a failure
			expiry_counter_o <= next_expiry;
		end
	end

	// ****************************************
	// event outputs
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			event_o <= 1'b0;
			event_hard_o <= 1'b0;
			event_soft_o <= 1'b0;
		end else begin
			event_o <= internal_event || pin_event;
			// internal event is always hard and drops a same-cycle soft pulse
			event_hard_o <= internal_event
				|| (pin_event && (pin_event_reset_type_o == wdog_pkg::PIN_TYPE_HARD));
			event_soft_o <= !internal_event && pin_event
				&& (pin_event_reset_type_o == wdog_pkg::PIN_TYPE_SOFT);
		end
	end

endmodule

// ==== testbench/wdog_event_mgr_sva.sv ====
`timescale 1ns/10ps
module wdog_event_mgr_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic host_fail_input_i,
	input wire logic off_mode_i,
	input wire logic power_up_load_i,
	input wire wdog_pkg::cfg_write_t cfg_i,
	input wire logic refresh_pending_flag_o,
	input wire logic [wdog_pkg::EXPIRY_W-1:0] expiry_counter_o,
	input wire logic [wdog_pkg::PERIOD_SEL_W-1:0] timer_period_sel_o,
	input wire logic [wdog_pkg::EXPIRY_W-1:0] expiry_limit_o,
	input wire logic timer_enable_o,
	input wire logic [wdog_pkg::MS_COUNT_W-1:0] ms_count_o,
	input wire logic timer_running_o,
	input wire logic event_o,
	input wire logic event_hard_o,
	input wire logic event_soft_o
);
	// ********
	// checks
	// ********
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	event_kind_a: assert property (event_o == (event_hard_o ^ event_soft_o))
		else $error("event kind wrong");
	pin_event_a: assert property ($fell(host_fail_input_i) && !off_mode_i |-> ##[1:8] event_o)
		else $error("pin event missing");
	off_clear_a: assert property (off_mode_i |=> !refresh_pending_flag_o && expiry_counter_o == 3'h0)
		else $error("off mode did not clear");
	refresh_dec_a: assert property ($fell(refresh_pending_flag_o) && !$past(off_mode_i) && $past(cfg_i.refresh_wr)
		|-> expiry_counter_o == ($past(expiry_counter_o) == 3'h0 ? 3'h0 : $past(expiry_counter_o) - 3'h1))
		else $error("refresh count wrong");
	refresh_restart_a: assert property ($fell(refresh_pending_flag_o) && !$past(off_mode_i)
		&& expiry_counter_o != expiry_limit_o |=> refresh_pending_flag_o && ms_count_o == 16'h0000)
		else $error("no restart after refresh");
	new_count_a: assert property ($rose(refresh_pending_flag_o) |-> ms_count_o == 16'h0000)
		else $error("flag set mid count");
	period_wr_a: assert property (cfg_i.period_wr && !power_up_load_i
		|=> timer_period_sel_o == $past(cfg_i.period_data))
		else $error("period write lost");
	timer_disabled_a: assert property (!timer_enable_o [*3] |-> ms_count_o == 16'h0000 && !timer_running_o)
		else $error("disabled timer runs");
	limit_event_a: assert property (expiry_counter_o == expiry_limit_o && $changed(expiry_counter_o)
		&& !$past(off_mode_i) |-> event_hard_o)
		else $error("limit event missing");
	cover property (event_hard_o);
	cover property (event_soft_o);
	cover property ($fell(refresh_pending_flag_o));
endmodule

bind wdog_event_mgr wdog_event_mgr_sva chk_u (.clk_i, .rst_i, .host_fail_input_i, .off_mode_i, .power_up_load_i,
	.cfg_i, .refresh_pending_flag_o, .expiry_counter_o, .timer_period_sel_o, .expiry_limit_o, .timer_enable_o,
	.ms_count_o, .timer_running_o, .event_o, .event_hard_o, .event_soft_o);

// ==== testbench/host_model.sv ====
`timescale 1ns/10ps
module host_model (
	input wire logic clk_i,
	input wire logic fail_i,
	input wire logic kick_i,
	output logic pin_o,
	output logic kick_o
);
	// ********
	// host side
	// ********
	int hold = 0;
	initial pin_o = 1'b1;
	initial kick_o = 1'b0;
	always @(posedge clk_i) begin
		kick_o <= kick_i;
		if (fail_i)
			hold = 8;
		pin_o <= (hold == 0);
		if (hold > 0)
			hold = hold - 1;
	end
endmodule

// ==== testbench/wdog_event_mgr_test.sv ====
`timescale 1ns/10ps
module wdog_event_mgr_test;
	localparam int T = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic off_mode_i = 1'b0;
	logic system_on_i = 1'b1;
	logic standby_i = 1'b0;
	logic released = 1'b0;
	logic pul = 1'b0;
	logic secure_en_i = 1'b0;
	logic window_mode_sel_i = 1'b0;
	logic fail = 1'b0;
	logic kick = 1'b0;
	logic pin, kick_wr, flag, run, ev, ev_hard, ev_soft, en, sten, ptype;
	logic [2:0] cnt, lim;
	logic [3:0] sel;
	logic [15:0] ms;
	wdog_pkg::otp_default_t otp = '{4'h1, 3'h7, 1'b1, 1'b0};
	wdog_pkg::cfg_write_t cfg = '0;
	wdog_pkg::cfg_write_t cfg_in;
	int bad_count = 0;
	int cmp_count = 0;
	always #20 clk_i = ~clk_i;
	always_comb begin
		cfg_in = cfg;
		cfg_in.refresh_wr = cfg.refresh_wr | kick_wr;
		cfg_in.refresh_data = cfg.refresh_data | kick_wr;
	end
	host_model host_u (.clk_i(clk_i), .fail_i(fail), .kick_i(kick), .pin_o(pin), .kick_o(kick_wr));
	wdog_event_mgr #(.TICK_CYCLES(T)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .host_fail_input_i(pin),
		.off_mode_i(off_mode_i), .system_on_i(system_on_i), .standby_i(standby_i),
		.host_reset_out_released_i(released), .power_up_load_i(pul), .secure_en_i(secure_en_i),
		.window_mode_sel_i(window_mode_sel_i), .otp_i(otp), .cfg_i(cfg_in), .refresh_pending_flag_o(flag),
		.expiry_counter_o(cnt), .timer_period_sel_o(sel), .expiry_limit_o(lim), .timer_enable_o(en),
		.standby_timer_enable_o(sten), .pin_event_reset_type_o(ptype), .ms_count_o(ms), .timer_running_o(run),
		.event_o(ev), .event_hard_o(ev_hard), .event_soft_o(ev_soft));
	// ********
	// helpers
	// ********
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wr(input wdog_pkg::cfg_write_t c);
		@(posedge clk_i) cfg <= c;
		@(posedge clk_i) cfg <= '0;
		@(negedge clk_i);
	endtask
	task automatic off_pulse();
		@(posedge clk_i) off_mode_i <= 1'b1;
		@(posedge clk_i) off_mode_i <= 1'b0;
		@(negedge clk_i);
		chk(cnt === 3'h0 && flag === 1'b0, "off clear");
	endtask
	task automatic wait_cnt(input logic [2:0] v, output int n);
		for (n = 0; n < 400 && cnt !== v; n++) @(negedge clk_i);
	endtask
	task automatic wait_ev(output int n);
		for (n = 0; n < 400 && ev !== 1'b1; n++) @(negedge clk_i);
	endtask
	task automatic kick_once();
		@(posedge clk_i) kick <= 1'b1;
		@(posedge clk_i) kick <= 1'b0;
		@(negedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_period();
		int n;
		for (int s = 0; s < 3; s++) begin
			wr('{period_wr:1'b1, period_data:s[3:0], default:'0});
			off_pulse();
			wait_cnt(3'h2, n);
			chk(n >= (T << s) && n <= (T << s) + 5, "expiry period");
		end
		wr('{period_wr:1'b1, period_data:4'h3, default:'0});
		off_pulse();
		for (n = 0; n < 400 && ms !== 16'h0002; n++) @(negedge clk_i);
		chk(n < 400, "count wait");
		wr('{period_wr:1'b1, period_data:4'h2, default:'0});
		chk(ms === 16'h0000, "period change restart");
		@(posedge clk_i) system_on_i <= 1'b0;
		for (n = 0; n < 400 && ms !== 16'h0001; n++) @(negedge clk_i);
		wr('{period_wr:1'b1, period_data:4'h3, default:'0});
		chk(ms === 16'h0001, "period change held");
		@(posedge clk_i) system_on_i <= 1'b1;
		$display("period done");
	endtask
	task automatic t_refresh();
		logic [2:0] exp [3] = '{3'h1, 3'h0, 3'h0};
		int n;
		wr('{period_wr:1'b1, period_data:4'h2, default:'0});
		off_pulse();
		wait_cnt(3'h2, n);
		wr('{refresh_wr:1'b1, default:'0});
		chk(flag === 1'b1 && cnt === 3'h2, "null refresh");
		for (int i = 0; i < 3; i++) begin
			kick_once();
			chk(flag === 1'b0 && cnt === exp[i], "refresh");
			@(negedge clk_i);
			chk(flag === 1'b1 && ms === 16'h0000, "restart");
		end
		@(posedge clk_i) window_mode_sel_i <= 1'b1;
		kick_once();
		chk(cnt === 3'h2 && flag === 1'b1, "early refresh");
		for (n = 0; n < 400 && ms !== 16'h0002; n++) @(negedge clk_i);
		kick_once();
		chk(cnt === 3'h1 && flag === 1'b0, "late refresh");
		@(posedge clk_i) window_mode_sel_i <= 1'b0;
		$display("refresh done");
	endtask
	task automatic t_limit();
		logic [2:0] lims [3] = '{3'h1, 3'h4, 3'h6};
		int n;
		foreach (lims[i]) begin
			wr('{limit_wr:1'b1, limit_data:lims[i], default:'0});
			off_pulse();
			wait_ev(n);
			chk(n < 400 && ev_hard === 1'b1 && ev_soft === 1'b0
				&& cnt === ((lims[i] <= 3'h2) ? 3'h2 : lims[i]), "limit event");
		end
		wr('{limit_wr:1'b1, limit_data:3'h7, default:'0});
		off_pulse();
		$display("limit done");
	endtask
	task automatic t_enable_pin();
		int n;
		@(posedge clk_i) secure_en_i <= 1'b1;
		wr('{enable_wr:1'b1, default:'0});
		chk(en === 1'b1, "unsecured enable write");
		wr('{enable_wr:1'b1, secure_write:1'b1, default:'0});
		chk(en === 1'b0, "secure disable");
		repeat (4 * T) @(negedge clk_i);
		chk(ms === 16'h0000 && run === 1'b0, "disabled timer");
		for (int t = 0; t < 2; t++) begin
			wr('{pin_type_wr:1'b1, pin_type_data:t[0], default:'0});
			chk(ptype === t[0], "pin type write");
			@(posedge clk_i) fail <= 1'b1;
			@(posedge clk_i) fail <= 1'b0;
			@(negedge clk_i);
			wait_ev(n);
			chk(n < 20 && ev_hard === t[0] && ev_soft === !t[0], "pin event");
			repeat (12) @(negedge clk_i);
		end
		$display("enable and pin done");
	endtask
	task automatic t_standby();
		int n;
		@(posedge clk_i) standby_i <= 1'b1;
		wr('{enable_wr:1'b1, enable_data:1'b1, secure_write:1'b1, default:'0});
		repeat (4 * T) @(negedge clk_i);
		chk(en === 1'b1 && ms === 16'h0000, "standby halt");
		wr('{standby_wr:1'b1, standby_data:1'b1, default:'0});
		chk(sten === 1'b1, "standby enable write");
		for (n = 0; n < 8 * T && ms === 16'h0000; n++) @(negedge clk_i);
		chk(n < 8 * T && run === 1'b1, "standby run");
		@(posedge clk_i) standby_i <= 1'b0;
		wr('{period_wr:1'b1, period_data:4'h3, default:'0});
		@(posedge clk_i) pul <= 1'b1;
		@(posedge clk_i) pul <= 1'b0;
		@(negedge clk_i);
		chk(sel === 4'h1 && lim === 3'h7 && en === 1'b1 && sten === 1'b0, "reload");
		$display("standby done");
	endtask
	// ********
	// main
	// ********
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk(sel === 4'h1 && lim === 3'h7 && en === 1'b1 && sten === 1'b0, "defaults");
		repeat (3 * T) @(negedge clk_i);
		chk(flag === 1'b0 && ms === 16'h0000, "held until release");
		@(posedge clk_i) released <= 1'b1;
		t_period();
		t_refresh();
		t_limit();
		t_enable_pin();
		t_standby();
		final_report();
	end
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule
